// File: rtl/oami_pkg.sv
// Purpose: Shared constants, types and helpers for the OR/move executor
// Assumes: One core clock, four phases to an instruction cycle
// Notes:   Register offsets are byte addresses on the plain register port
package oami_pkg;

  // ==========================================================
  // Register port map
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_WREG      = 8'h04;
  localparam logic [7:0]  REG_BANK      = 8'h08;
  localparam logic [7:0]  REG_PTR0      = 8'h0c;
  localparam logic [7:0]  REG_PTR1      = 8'h10;
  localparam logic [7:0]  REG_PTR2      = 8'h14;
  localparam logic [7:0]  REG_STATUS    = 8'h18;
  localparam int          CTRL_EXT_BIT  = 0;
  localparam int          STAT_Z_BIT    = 0;
  localparam int          STAT_N_BIT    = 1;

  // ==========================================================
  // Reset values
  localparam logic        EXT_EN_RESET  = 1'b0;
  localparam logic [7:0]  WREG_RESET    = 8'h00;
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  localparam logic [11:0] PTR_RESET     = 12'h000;

  // ==========================================================
  // Data space layout
  localparam logic [11:0] WREG_DADDR    = 12'hfe8;
  localparam logic [11:0] BANK_DADDR    = 12'hfe0;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [7:0]  INDEXED_MAX   = 8'h5f;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
  localparam logic [1:0]  PTR_COUNT     = 2'h3;

  // ==========================================================
  // Opcode fields
  localparam logic [7:0]  OPC_OR_LIT    = 8'h09;
  localparam logic [7:0]  OPC_LIT_LOAD  = 8'h0e;
  localparam logic [7:0]  OPC_BANK_LOAD = 8'h01;
  localparam logic [5:0]  OPC_OR_REG    = 6'h04;
  localparam logic [5:0]  OPC_REG_MOVE  = 6'h14;
  localparam logic [6:0]  OPC_ACC_STORE = 7'h37;
  localparam logic [9:0]  OPC_PTR_LOAD  = 10'h3b8;
  localparam logic [3:0]  OPC_MEM_MOVE  = 4'hc;
  localparam logic [3:0]  OPC_SECOND    = 4'hf;

  // Instruction cycle phases
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } oami_phase_t;

  // Executed operation kinds
  typedef enum logic [3:0] {
    OP_NONE, OP_OR_LIT, OP_OR_REG, OP_PTR_LOAD, OP_REG_MOVE,
    OP_MEM_MOVE, OP_BANK_LOAD, OP_LIT_LOAD, OP_ACC_STORE
  } oami_op_t;

  // Decode a first program word
  function automatic oami_op_t oami_decode(input logic [15:0] word);
    oami_op_t op;
    op = OP_NONE;
    if (word[15:8] == OPC_OR_LIT) op = OP_OR_LIT;
    else if (word[15:8] == OPC_LIT_LOAD) op = OP_LIT_LOAD;
    else if (word[15:8] == OPC_BANK_LOAD) op = OP_BANK_LOAD;
    else if (word[15:10] == OPC_OR_REG) op = OP_OR_REG;
    else if (word[15:10] == OPC_REG_MOVE) op = OP_REG_MOVE;
    else if (word[15:9] == OPC_ACC_STORE) op = OP_ACC_STORE;
    else if (word[15:6] == OPC_PTR_LOAD) op = OP_PTR_LOAD;
    else if (word[15:12] == OPC_MEM_MOVE) op = OP_MEM_MOVE;
    return op;
  endfunction : oami_decode

  // Address held inside the core rather than in data memory
  function automatic logic oami_core_hit(input logic [11:0] addr);
    return (addr == WREG_DADDR) || (addr == BANK_DADDR);
  endfunction : oami_core_hit

endpackage : oami_pkg

// File: rtl/oami_addr_if.sv
// Purpose: Carries the file-field address request and its answer
// Assumes: Purely combinational path
// Notes:   gen side forms the address, user side supplies the fields
`timescale 1ns/1ps
`default_nettype none
interface oami_addr_if;
  logic        a_bit;
  logic [7:0]  f_field;
  logic [3:0]  bank;
  logic        ext_en;
  logic [11:0] ptr2;
  logic [11:0] addr;
  logic        indexed;

  modport gen  (input a_bit, f_field, bank, ext_en, ptr2,
                output addr, indexed);
  modport user (output a_bit, f_field, bank, ext_en, ptr2,
                input addr, indexed);
endinterface : oami_addr_if
`default_nettype wire

// File: rtl/oami_addr_gen.sv
// Purpose: Forms a 12-bit data address from the file field
// Assumes: Bank and pointer values are stable during decode
// Notes:   Indexed offset uses the third file pointer as base
`timescale 1ns/1ps
`default_nettype none
module oami_addr_gen
  import oami_pkg::*;
(
  oami_addr_if.gen ai
);

  // ==========================================================
  // Address selection
  always_comb
  begin
    ai.indexed = 1'b0;
    if (ai.a_bit)
    begin
      ai.addr = {ai.bank, ai.f_field};
    end
    else if (ai.ext_en && (ai.f_field <= INDEXED_MAX))
    begin
      ai.indexed = 1'b1;
      ai.addr    = ai.ptr2 + {4'h0, ai.f_field};
    end
    else if (ai.f_field < ACCESS_SPLIT)
    begin
      ai.addr = {4'h0, ai.f_field};
    end
    else
    begin
      ai.addr = {ACCESS_HI_BNK, ai.f_field};
    end
  end

endmodule : oami_addr_gen
`default_nettype wire

// File: rtl/oami_exec.sv
// Purpose: Executes the OR, pointer load, move, bank and store group
// Assumes: Program words arrive with a valid; memory reads answer a
//          cycle after the read strobe
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module oami_exec
  import oami_pkg::*;
#(
  parameter int unsigned RADDR_W = 8
)
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  output logic                    instr_ready,
  output logic [11:0]             dmem_addr,
  output logic                    dmem_rd,
  input  wire logic [7:0]         dmem_rdata,
  output logic                    dmem_wr,
  output logic [7:0]              dmem_wdata,
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata
);

  // ==========================================================
  // State
  oami_phase_t phase_r,  phase_nxt;
  oami_op_t    op_r,     op_nxt;
  logic        second_r, second_nxt;
  logic [15:0] ir_r,     ir_nxt;
  logic [11:0] addr_r,   addr_nxt;
  logic [7:0]  result_r, result_nxt;
  logic [1:0]  sel_r,    sel_nxt;
  logic [7:0]  w_r,      w_nxt;
  logic [3:0]  bank_r,   bank_nxt;
  logic [11:0] ptr_r     [0:2];
  logic [11:0] ptr_nxt   [0:2];
  logic        flag_n_r, flag_n_nxt;
  logic        flag_z_r, flag_z_nxt;
  logic        ext_en_r, ext_en_nxt;
  logic [11:0] daddr_r,  daddr_nxt;
  logic        drd_r,    drd_nxt;
  logic        dwr_r,    dwr_nxt;
  logic [7:0]  dwdata_r, dwdata_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  oami_op_t    op_q1;
  logic        hit;
  logic [7:0]  opnd;
  logic        int_wr;
  logic [7:0]  int_val;

  oami_addr_if agen_if ();

  // ==========================================================
  // Address former for the word being decoded
  assign agen_if.a_bit   = instr_word[8];
  assign agen_if.f_field = instr_word[7:0];
  assign agen_if.bank    = bank_r;
  assign agen_if.ext_en  = ext_en_r;
  assign agen_if.ptr2    = ptr_r[2];

  oami_addr_gen oami_addr_gen_i (
    .ai (agen_if.gen)
  );

  // Operation for the word on the fetch port
  assign op_q1 = second_r ? op_r : oami_decode(instr_word);
  // Operand comes from W or bank select when they are addressed
  assign hit   = oami_core_hit(addr_r);
  assign opnd  = (addr_r == WREG_DADDR) ? w_r :
                 (addr_r == BANK_DADDR) ? {4'h0, bank_r} : dmem_rdata;

  // ==========================================================
  // Instruction sequencer and execution
  always_comb
  begin
    phase_nxt  = phase_r;
    op_nxt     = op_r;
    second_nxt = second_r;
    ir_nxt     = ir_r;
    addr_nxt   = addr_r;
    result_nxt = result_r;
    sel_nxt    = sel_r;
    w_nxt      = w_r;
    bank_nxt   = bank_r;
    ptr_nxt    = ptr_r;
    flag_n_nxt = flag_n_r;
    flag_z_nxt = flag_z_r;
    daddr_nxt  = daddr_r;
    drd_nxt    = 1'b0;
    dwr_nxt    = 1'b0;
    dwdata_nxt = dwdata_r;
    int_wr     = 1'b0;
    int_val    = result_r;
    case (phase_r)
      PH_Q1:
      begin
        // Decode; wait here until the word is offered
        if (instr_valid)
        begin
          phase_nxt = PH_Q2;
          ir_nxt    = instr_word;
          op_nxt    = op_q1;
          if (op_q1 == OP_MEM_MOVE)
            addr_nxt = instr_word[11:0];
          else
            addr_nxt = agen_if.addr;
          // Only first words of reading ops fetch from memory
          if (!second_r &&
              ((op_q1 == OP_OR_REG) || (op_q1 == OP_REG_MOVE) ||
               (op_q1 == OP_MEM_MOVE)))
          begin
            drd_nxt   = !oami_core_hit(addr_nxt);
            daddr_nxt = addr_nxt;
          end
        end
      end
      PH_Q2:
      begin
        // Read in flight
        phase_nxt = PH_Q3;
      end
      PH_Q3:
      begin
        // Process the operand and set up any memory write
        phase_nxt = PH_Q4;
        daddr_nxt = addr_r;
        case (op_r)
          OP_OR_LIT:    result_nxt = w_r | ir_r[7:0];
          OP_OR_REG:
          begin
            result_nxt = w_r | opnd;
            dwr_nxt    = ir_r[9] && !hit;
          end
          OP_REG_MOVE:
          begin
            result_nxt = opnd;
            dwr_nxt    = ir_r[9] && !hit;
          end
          OP_ACC_STORE:
          begin
            result_nxt = w_r;
            dwr_nxt    = !hit;
          end
          OP_LIT_LOAD:  result_nxt = ir_r[7:0];
          OP_BANK_LOAD: result_nxt = ir_r[7:0];
          OP_MEM_MOVE:
          begin
            if (!second_r)
              result_nxt = opnd;
            else
              dwr_nxt = (ir_r[15:12] == OPC_SECOND) && !hit;
          end
          default:      result_nxt = result_r;
        endcase
        dwdata_nxt = result_nxt;
      end
      PH_Q4:
      begin
        // Write back to core registers and move on
        phase_nxt  = PH_Q1;
        second_nxt = 1'b0;
        case (op_r)
          OP_OR_LIT, OP_LIT_LOAD:
          begin
            w_nxt = result_r;
          end
          OP_OR_REG, OP_REG_MOVE:
          begin
            if (!ir_r[9])
              w_nxt = result_r;
            else
              int_wr = hit;
          end
          OP_ACC_STORE:
          begin
            int_wr = hit;
          end
          OP_BANK_LOAD:
          begin
            bank_nxt = result_r[3:0];
          end
          OP_PTR_LOAD:
          begin
            if (!second_r)
            begin
              second_nxt = 1'b1;
              sel_nxt    = ir_r[5:4];
              if (ir_r[5:4] < PTR_COUNT)
                ptr_nxt[ir_r[5:4]][11:8] = ir_r[3:0];
            end
            else if ((ir_r[15:12] == OPC_SECOND) && (sel_r < PTR_COUNT))
            begin
              ptr_nxt[sel_r][7:0] = ir_r[7:0];
            end
          end
          OP_MEM_MOVE:
          begin
            if (!second_r)
              second_nxt = 1'b1;
            else
              int_wr = hit && (ir_r[15:12] == OPC_SECOND);
          end
          default:
          begin
            second_nxt = 1'b0;
          end
        endcase
        // Only OR and register move touch N and Z
        if ((op_r == OP_OR_LIT) || (op_r == OP_OR_REG) ||
            (op_r == OP_REG_MOVE))
        begin
          flag_n_nxt = result_r[7];
          flag_z_nxt = (result_r == 8'h00);
        end
        // Writes that land on W or bank select stay inside
        if (int_wr)
        begin
          if (addr_r == WREG_DADDR)
            w_nxt = int_val;
          else
            bank_nxt = int_val[3:0];
        end
      end
      default:
      begin
        phase_nxt = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_r  <= PH_Q1;
      op_r     <= OP_NONE;
      second_r <= 1'b0;
      ir_r     <= 16'h0000;
      addr_r   <= 12'h000;
      result_r <= 8'h00;
      sel_r    <= 2'h0;
      w_r      <= WREG_RESET;
      bank_r   <= BANK_RESET;
      ptr_r    <= '{PTR_RESET, PTR_RESET, PTR_RESET};
      flag_n_r <= 1'b0;
      flag_z_r <= 1'b0;
      daddr_r  <= 12'h000;
      drd_r    <= 1'b0;
      dwr_r    <= 1'b0;
      dwdata_r <= 8'h00;
    end
    else
    begin
      phase_r  <= phase_nxt;
      op_r     <= op_nxt;
      second_r <= second_nxt;
      ir_r     <= ir_nxt;
      addr_r   <= addr_nxt;
      result_r <= result_nxt;
      sel_r    <= sel_nxt;
      w_r      <= w_nxt;
      bank_r   <= bank_nxt;
      ptr_r    <= ptr_nxt;
      flag_n_r <= flag_n_nxt;
      flag_z_r <= flag_z_nxt;
      daddr_r  <= daddr_nxt;
      drd_r    <= drd_nxt;
      dwr_r    <= dwr_nxt;
      dwdata_r <= dwdata_nxt;
    end
  end

  // ==========================================================
  // Register port: control write, state readback
  always_comb
  begin
    ext_en_nxt = ext_en_r;
    rdata_nxt  = 32'h0000_0000;
    if (reg_wr && (reg_addr == RADDR_W'(REG_CTRL)))
      ext_en_nxt = reg_wdata[CTRL_EXT_BIT];
    if (reg_rd)
    begin
      case (reg_addr)
        RADDR_W'(REG_CTRL):   rdata_nxt[CTRL_EXT_BIT] = ext_en_r;
        RADDR_W'(REG_WREG):   rdata_nxt[7:0] = w_r;
        RADDR_W'(REG_BANK):   rdata_nxt[7:0] = {4'h0, bank_r};
        RADDR_W'(REG_PTR0):   rdata_nxt[11:0] = ptr_r[0];
        RADDR_W'(REG_PTR1):   rdata_nxt[11:0] = ptr_r[1];
        RADDR_W'(REG_PTR2):   rdata_nxt[11:0] = ptr_r[2];
        RADDR_W'(REG_STATUS):
        begin
          rdata_nxt[STAT_Z_BIT] = flag_z_r;
          rdata_nxt[STAT_N_BIT] = flag_n_r;
        end
        default:              rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_en_r <= EXT_EN_RESET;
      rdata_r  <= 32'h0000_0000;
    end
    else
    begin
      ext_en_r <= ext_en_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign instr_ready = (phase_r == PH_Q1);
  assign dmem_addr   = daddr_r;
  assign dmem_rd     = drd_r;
  assign dmem_wr     = dwr_r;
  assign dmem_wdata  = dwdata_r;
  assign reg_rdata   = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_or_literal_w: assert property (
    (phase_r == PH_Q4) && (op_r == OP_OR_LIT) |=>
      (w_r == ($past(w_r) | $past(ir_r[7:0]))))
    else $error("literal OR result wrong");
  a_or_reg_zero: assert property (
    (phase_r == PH_Q4) && (op_r == OP_OR_REG) |=>
      (flag_z_r == ($past(result_r) == 8'h00)) &&
      (flag_n_r == $past(result_r[7])))
    else $error("register OR flags wrong");
  a_dest_to_w: assert property (
    (phase_r == PH_Q4) && (op_r == OP_REG_MOVE) && !ir_r[9] |->
      !dmem_wr ##1 (w_r == $past(result_r)))
    else $error("destination W not honoured");
  a_bank_addr: assert property (
    instr_valid && instr_ready && agen_if.a_bit |->
      (agen_if.addr == {bank_r, instr_word[7:0]}))
    else $error("banked address wrong");
  a_indexed_addr: assert property (
    !agen_if.a_bit && ext_en_r && (instr_word[7:0] <= INDEXED_MAX) |->
      agen_if.indexed &&
      (agen_if.addr == ptr_r[2] + {4'h0, instr_word[7:0]}))
    else $error("indexed address wrong");
  a_ptr_upper: assert property (
    (phase_r == PH_Q4) && (op_r == OP_PTR_LOAD) && !second_r &&
      (ir_r[5:4] == 2'h0) |=> (ptr_r[0][11:8] == $past(ir_r[3:0])) &&
      second_r)
    else $error("pointer upper nibble not loaded");
  a_move_no_flags: assert property (
    (op_r == OP_MEM_MOVE) && (phase_r == PH_Q4) |=>
      $stable(flag_n_r) && $stable(flag_z_r))
    else $error("memory move changed flags");
  a_no_dummy_read: assert property (
    second_r && (op_r == OP_MEM_MOVE) |-> !dmem_rd)
    else $error("memory move issued a dummy read");
  a_bank_load: assert property (
    (phase_r == PH_Q4) && (op_r == OP_BANK_LOAD) |=>
      (bank_r == $past(ir_r[3:0])))
    else $error("bank load wrong");
  a_store_write: assert property (
    (phase_r == PH_Q4) && (op_r == OP_ACC_STORE) && !hit |->
      dmem_wr && (dmem_wdata == w_r) && (dmem_addr == addr_r))
    else $error("store did not write W");
  a_phase_order: assert property (
    (phase_r == PH_Q2) |=> (phase_r == PH_Q3) ##1 (phase_r == PH_Q4)
      ##1 (phase_r == PH_Q1))
    else $error("phase order broken");

  c_or_literal: cover property ((phase_r == PH_Q4) && (op_r == OP_OR_LIT));
  c_mem_move:   cover property (dmem_wr && (op_r == OP_MEM_MOVE));
  c_ptr_load:   cover property ((op_r == OP_PTR_LOAD) && second_r &&
                                (phase_r == PH_Q4));
  c_store:      cover property (dmem_wr && (op_r == OP_ACC_STORE));

endmodule : oami_exec
`default_nettype wire

// File: dv/oami_dmem_model.sv
// Purpose: Data memory on the far side of the executor
// Assumes: Read data are due in the cycle after the read strobe only
// Notes:   Outside that cycle the read bus toggles so stale data fail
`timescale 1ns/1ps
`default_nettype none
module oami_dmem_model
(
  input  wire logic        core_clk,
  input  wire logic [11:0] dmem_addr,
  input  wire logic        dmem_rd,
  input  wire logic        dmem_wr,
  input  wire logic [7:0]  dmem_wdata,
  output logic      [7:0]  dmem_rdata
);
  // ==========================================================
  // Storage and access log
  logic [7:0]  mem [0:4095];
  int          rd_cnt  = 0;
  int          wr_cnt  = 0;
  logic [11:0] last_wa = 12'h000;

  // Clear storage and read bus at start
  initial
  begin
    dmem_rdata = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Answer a read for one cycle, invert the bus otherwise
  always @(posedge core_clk)
  begin
    if (dmem_wr)
    begin
      mem[dmem_addr] <= dmem_wdata;
      wr_cnt         <= wr_cnt + 1;
      last_wa        <= dmem_addr;
    end
    if (dmem_rd)
    begin
      dmem_rdata <= mem[dmem_addr];
      rd_cnt     <= rd_cnt + 1;
    end
    else
      dmem_rdata <= ~dmem_rdata; // Released bus never holds a value
  end
endmodule : oami_dmem_model
`default_nettype wire

// File: dv/or_and_move_instruction_exec_tb_top.sv
// Purpose: Self-checking bench for the OR/move executor
// Assumes: Register and program stimulus change right after clock edges
// Notes:   Expected values are worked out here, never read from the core
`timescale 1ns/1ps
`default_nettype none
module or_and_move_instruction_exec_tb_top
  import oami_pkg::*;
;
  logic        core_clk;
  logic        rst;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic        instr_ready;
  logic [11:0] dmem_addr;
  logic        dmem_rd;
  logic [7:0]  dmem_rdata;
  logic        dmem_wr;
  logic [7:0]  dmem_wdata;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  int          err_total   = 0;
  int          check_count = 0;

  // ==========================================================
  // Core and its memory
  oami_exec #(.RADDR_W(8)) oami_exec_i (.core_clk, .rst, .instr_valid,
    .instr_word, .instr_ready, .dmem_addr, .dmem_rd, .dmem_rdata,
    .dmem_wr, .dmem_wdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  oami_dmem_model oami_dmem_model_i (.core_clk, .dmem_addr, .dmem_rd,
    .dmem_wr, .dmem_wdata, .dmem_rdata);

  // 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Let an edge pass so a following write never re-raises the strobe
    @(posedge core_clk);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge core_clk);
  endtask : rreg

  task automatic chkmem(input logic [11:0] a, input logic [7:0] e);
    chk({24'h0, oami_dmem_model_i.mem[a]}, {24'h0, e});
  endtask : chkmem

  // Offer a word and hold it until the decode phase takes it
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    instr_valid <= 1'b1;
    instr_word  <= w;
    #1;
    while (instr_ready !== 1'b1 && n < 16)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(32'(instr_ready), 32'h1);
    @(posedge core_clk);
  endtask : issue

  // Release the word and watch the four-phase cycle finish
  task automatic done_instr;
    instr_valid <= 1'b0;
    for (int i = 1; i <= 3; i++)
    begin
      @(posedge core_clk);
      #1;
      chk(32'(instr_ready), 32'(i == 3));
    end
    @(posedge core_clk);
  endtask : done_instr

  task automatic run(input logic [15:0] w);
    issue(w);
    done_instr;
  endtask : run

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    wreg(REG_WREG, 32'h0000_00ff); // Read-only, must be ignored
    for (int a = 0; a <= 8'h1c; a += 4)
      rreg(8'(a), 32'h0);
  endtask : t_reset

  task automatic t_literal;
    run(16'h0e9a);
    rreg(REG_WREG, 32'h9a);
    run(16'h0935);
    rreg(REG_WREG, 32'hbf);
    rreg(REG_STATUS, 32'h2);
    run(16'h0e00);
    run(16'h0900);
    rreg(REG_STATUS, 32'h1);
    issue(16'h0e11);
    issue(16'h0922);
    done_instr;
    rreg(REG_WREG, 32'h33);
    rreg(REG_STATUS, 32'h0);
  endtask : t_literal

  task automatic t_bank;
    run(16'h01f5);
    rreg(REG_BANK, 32'h05);
  endtask : t_bank

  task automatic t_store;
    run(16'h0e00);
    run(16'h0900);
    run(16'h0e4f);
    run(16'h6f23);
    chkmem(12'h523, 8'h4f);
    run(16'h6e70);
    chkmem(12'hf70, 8'h4f);
    run(16'h6e10);
    chkmem(12'h010, 8'h4f);
    rreg(REG_STATUS, 32'h1);
  endtask : t_store

  task automatic t_orreg;
    oami_dmem_model_i.mem[12'h013] = 8'h13;
    oami_dmem_model_i.mem[12'h522] = 8'h40;
    run(16'h0e91);
    run(16'h1013);
    rreg(REG_WREG, 32'h93);
    rreg(REG_STATUS, 32'h2);
    chkmem(12'h013, 8'h13);
    run(16'h0e04);
    run(16'h1213);
    chkmem(12'h013, 8'h17);
    run(16'h1322);
    chkmem(12'h522, 8'h44);
    rreg(REG_WREG, 32'h04);
    rreg(REG_STATUS, 32'h0);
  endtask : t_orreg

  task automatic t_move;
    oami_dmem_model_i.mem[12'hfaa] = 8'h80;
    run(16'h50aa);
    rreg(REG_WREG, 32'h80);
    rreg(REG_STATUS, 32'h2);
    run(16'h5322);
    chk(32'(oami_dmem_model_i.last_wa), 32'h522);
    rreg(REG_WREG, 32'h80);
    run(16'h5000);
    rreg(REG_STATUS, 32'h1);
  endtask : t_move

  task automatic t_ptr;
    for (int s = 0; s < 3; s++)
    begin
      issue({10'h3b8, 2'(s), 4'(s + 1)});
      issue({8'hf0, 8'(8'ha0 + s)});
      done_instr;
      rreg(8'(8'h0c + 4 * s), {20'h0, 4'(s + 1), 8'(8'ha0 + s)});
    end
    issue({10'h3b8, 2'h3, 4'h7}); // Selector 3 must be ignored
    issue(16'hf055);
    done_instr;
    rreg(REG_PTR0, 32'h01a0);
    rreg(REG_PTR1, 32'h02a1);
    rreg(REG_PTR2, 32'h03a2);
    issue(16'hee2c);
    done_instr;
    rreg(REG_PTR2, 32'h0ca2);
    run(16'hf0ab);
    rreg(REG_PTR2, 32'h0cab);
  endtask : t_ptr

  task automatic t_index;
    logic [8:0]  af [4] = '{9'h005, 9'h05f, 9'h060, 9'h105};
    logic [11:0] ea [4] = '{12'hcb0, 12'hd0a, 12'hf60, 12'h505};
    wreg(REG_CTRL, 32'h1);
    rreg(REG_CTRL, 32'h1);
    run(16'h0e66);
    for (int i = 0; i < 4; i++)
    begin
      run({7'h37, af[i]});
      chk(32'(oami_dmem_model_i.last_wa), 32'(ea[i]));
      chkmem(ea[i], 8'h66);
    end
    wreg(REG_CTRL, 32'h0);
  endtask : t_index

  task automatic t_mm;
    int r0;
    int w0;
    oami_dmem_model_i.mem[12'h123] = 8'h33;
    r0 = oami_dmem_model_i.rd_cnt;
    w0 = oami_dmem_model_i.wr_cnt;
    issue(16'hc123);
    done_instr;
    chk(32'(oami_dmem_model_i.rd_cnt - r0), 32'h1);
    chk(32'(oami_dmem_model_i.wr_cnt - w0), 32'h0);
    issue(16'hf456);
    done_instr;
    chk(32'(oami_dmem_model_i.rd_cnt - r0), 32'h1);
    chk(32'(oami_dmem_model_i.wr_cnt - w0), 32'h1);
    chkmem(12'h456, 8'h33);
    rreg(REG_STATUS, 32'h1);
    run(16'h0e5a);
    issue(16'hcfe8);
    issue(16'hf200);
    done_instr;
    chkmem(12'h200, 8'h5a);
    chk(32'(oami_dmem_model_i.rd_cnt - r0), 32'h1);
    issue(16'hc123);
    issue(16'hffe8);
    done_instr;
    rreg(REG_WREG, 32'h33);
    chk(32'(oami_dmem_model_i.wr_cnt - w0), 32'h2);
    issue(16'hc123);
    issue(16'h0456); // Second word without its prefix
    done_instr;
    chk(32'(oami_dmem_model_i.wr_cnt - w0), 32'h2);
    rreg(REG_WREG, 32'h33);
  endtask : t_mm

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst         = 1'b1;
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_literal;
    t_bank;
    t_store;
    t_orreg;
    t_move;
    t_ptr;
    t_index;
    t_mm;
    finish_test;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    finish_test;
  end
endmodule : or_and_move_instruction_exec_tb_top
`default_nettype wire
